// File: design/bgd_phase.sv
// One bridge phase: dead time insertion and bootstrap charge management
`timescale 1ns/1ps
`default_nettype none
module bgd_phase
    import bgd_pkg::*;
(
    input  wire logic              ref_clk_i,      // System clock
    input  wire logic              rst_n_i,        // Synchronous reset, active low
    input  wire logic              enable_i,       // Gates allowed
    input  wire logic              want_high_i,    // Request high side on
    input  wire logic              want_low_i,     // Request low side on
    input  wire logic              boot_on_ok_i,   // Bootstrap above turn-on threshold
    input  wire logic              boot_off_ok_i,  // Bootstrap above turn-off threshold
    input  wire logic [CNT_W-1:0]  dead_cyc_i,     // Dead time in cycles
    input  wire logic              clear_fault_i,  // Clear latched fault
    output var bgd_gate_t          gate_o,         // Registered gate pair
    output logic                   boot_fault_o    // Sticky bootstrap fault
);
    bgd_phase_t       st_r, st_nxt;                // Phase state
    logic [CNT_W-1:0] cnt_r, cnt_nxt;              // Dead and charge timer
    logic             flt_r, flt_nxt;              // Fault flag
    logic             chg_done_r, chg_done_nxt;    // Charge stretch elapsed

    // Next state of the phase
    always_comb
    begin
        st_nxt       = st_r;
        cnt_nxt      = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
        // Clear applied first, so a fault raised below in the same cycle wins
        flt_nxt      = clear_fault_i ? 1'b0 : flt_r;
        chg_done_nxt = chg_done_r;
        case (st_r)
            PH_OFF:
            begin
                if (want_high_i || want_low_i)
                begin
                    st_nxt  = want_high_i ? PH_DEAD_TO_HI : PH_DEAD_TO_LO;
                    cnt_nxt = dead_cyc_i;
                end
            end
            PH_DEAD_TO_HI:
            begin
                if (!want_high_i)
                    st_nxt = PH_OFF;
                else if (cnt_r == '0)
                begin
                    if (boot_on_ok_i)
                        st_nxt = PH_HIGH;
                    else
                    begin
                        // Low side recharges the capacitor before the high side
                        st_nxt       = PH_CHARGE;
                        cnt_nxt      = CNT_W'(BOOT_CHG_CYC);
                        chg_done_nxt = 1'b0;
                    end
                end
            end
            PH_CHARGE:
            begin
                // Hold low side a short minimum so a tight duty still refills
                if (cnt_r <= CNT_W'(BOOT_CHG_CYC - MIN_CHG_CYC))
                    chg_done_nxt = 1'b1;
                if (!want_high_i)
                    st_nxt = PH_LOW;
                else if (boot_on_ok_i && chg_done_r)
                begin
                    st_nxt  = PH_DEAD_TO_HI;
                    cnt_nxt = dead_cyc_i;
                end
                else if (cnt_r == '0)
                begin
                    flt_nxt = 1'b1;
                    st_nxt  = PH_OFF;
                end
            end
            PH_HIGH:
            begin
                if (!want_high_i || !boot_off_ok_i)
                begin
                    // Turn off, then low side after dead time; recharge if sagging
                    st_nxt  = PH_DEAD_TO_LO;
                    cnt_nxt = dead_cyc_i;
                end
            end
            PH_DEAD_TO_LO:
            begin
                if (cnt_r == '0)
                begin
                    if (want_high_i)
                    begin
                        st_nxt       = PH_CHARGE;
                        cnt_nxt      = CNT_W'(BOOT_CHG_CYC);
                        chg_done_nxt = 1'b0;
                    end
                    else if (want_low_i)
                        st_nxt = PH_LOW;
                    else
                        st_nxt = PH_OFF;
                end
            end
            PH_LOW:
            begin
                if (want_high_i)
                begin
                    st_nxt  = PH_DEAD_TO_HI;
                    cnt_nxt = dead_cyc_i;
                end
                else if (!want_low_i)
                    st_nxt = PH_OFF;
            end
            default:
                st_nxt = PH_OFF;
        endcase
        if (!enable_i)
            st_nxt = PH_OFF;
    end

    // Register the phase state
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r       <= PH_OFF;
            cnt_r      <= '0;
            flt_r      <= 1'b0;
            chg_done_r <= 1'b0;
            gate_o     <= '0;
            boot_fault_o <= 1'b0;
        end
        else
        begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            flt_r      <= flt_nxt;
            chg_done_r <= chg_done_nxt;
            // Gates decoded from one state, so never both on
            gate_o.high  <= (st_nxt == PH_HIGH);
            gate_o.low   <= (st_nxt == PH_LOW) || (st_nxt == PH_CHARGE);
            boot_fault_o <= flt_nxt;
        end
    end
endmodule
`default_nettype wire

// File: design/bgd_pkg.sv
// Package for the bridge gate drive control block: constants and carrier types
package bgd_pkg;
    localparam int unsigned CLK_PERIOD_NS      = 100;              // ref_clk_i period
    localparam int unsigned DT_STEP_NS         = 50;               // Dead time per setting step
    localparam int unsigned DT_MIN_NS          = 100;              // Least dead time
    localparam logic [5:0]  DT_MIN_SETTING     = 6'h02;            // Settings at or below give the least time
    localparam int unsigned RES_PULSE_NS       = 10000;            // Reset pulse time, default
    localparam int unsigned PUMP_WAIT_NS       = 3000000;          // Pump settle wait after sleep
    localparam int unsigned BOOT_CHARGE_NS     = 20000;            // Longest recharge attempt
    localparam int unsigned MIN_CHARGE_NS      = 1000;             // Least forced recharge slot
    // Cycle counts derived from the clock rate
    localparam int unsigned DT_MIN_CYC    = (DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RES_PULSE_CYC = (RES_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PUMP_WAIT_CYC = PUMP_WAIT_NS / CLK_PERIOD_NS;
    localparam int unsigned BOOT_CHG_CYC  = BOOT_CHARGE_NS / CLK_PERIOD_NS;
    localparam int unsigned MIN_CHG_CYC   = (MIN_CHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NPHASE        = 3;                     // Bridge phases
    localparam int unsigned DT_W          = 6;                     // Dead time setting width
    localparam int unsigned CNT_W         = 16;                    // Per phase timer width
    localparam int unsigned SLP_W         = 16;                    // Sleep and pump timer width

    // Gate pair for one phase
    typedef struct packed {
        logic high;                                                // High-side gate
        logic low;                                                 // Low-side gate
    } bgd_gate_t;

    // Phase drive states
    typedef enum logic [2:0] {
        PH_OFF,
        PH_DEAD_TO_HI,
        PH_CHARGE,
        PH_HIGH,
        PH_DEAD_TO_LO,
        PH_LOW
    } bgd_phase_t;

    // Chip power states
    typedef enum logic [1:0] {
        PW_RUN,
        PW_SLEEP,
        PW_PUMP_WAIT
    } bgd_power_t;
endpackage

// File: design/bgd_top.sv
// Top of the bridge gate drive control: power sequencing and three phases
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - High side only with bootstrap above on-threshold
// - Weak bootstrap: low side recharges, then high
// - Sag below off-threshold while high forces recharge
// - High duty may insert repeated recharge cycles
// - Recharge failure raises bootstrap fault
// - Dead time before every complementary turn-on
// - One six-bit setting serves all phases
// - Dead time is setting times 50 ns; odd settings round down to whole 100 ns cycles
// - Settings 0 to 2 give 100 ns
// - Long reset low enters sleep, all off
// - Sleep clears latched faults and flags
// - After sleep, gates off until pump valid
// - Short reset pulse clears faults, no sleep
// - Low gate high turns low transistor on
// - High gate high turns high transistor on
// - PWM low: high off, low on
module bgd_top
    import bgd_pkg::*;
#(
    parameter int unsigned RES_CYC  = RES_PULSE_CYC,          // Reset pulse time in cycles
    parameter int unsigned PUMP_CYC = PUMP_WAIT_CYC           // Pump settle limit in cycles
)
(
    input  wire logic              ref_clk_i,                // 10 MHz system clock
    input  wire logic              rst_n_i,                  // Synchronous reset, active low
    input  wire logic              sleep_reset_n_i,          // Sleep and fault reset input
    input  wire logic              pwm_i,                    // PWM, low chops to low side
    input  wire logic [NPHASE-1:0] phase_high_i,             // Commutation: high side wanted
    input  wire logic [NPHASE-1:0] phase_low_i,              // Commutation: low side wanted
    input  wire logic [NPHASE-1:0] boot_on_ok_i,             // Bootstrap above turn-on level
    input  wire logic [NPHASE-1:0] boot_off_ok_i,            // Bootstrap above turn-off level
    input  wire logic              pump_valid_i,             // Charge pump ready
    input  wire logic [DT_W-1:0]   dead_time_setting_i,      // Dead time setting
    output logic [NPHASE-1:0]      high_gate_out_o,          // High-side gates
    output logic [NPHASE-1:0]      low_gate_out_o,           // Low-side gates
    output logic [NPHASE-1:0]      boot_fault_o,             // Latched bootstrap faults
    output logic                   fault_clear_o,            // Pulse: faults being cleared
    output logic                   sleep_o,                  // Sleep state, internals off
    output logic                   pump_enable_o             // Pump regulator enable
);
    bgd_power_t       pw_r, pw_nxt;                          // Power state
    logic [SLP_W-1:0] low_cnt_r, low_cnt_nxt;                // Reset-low length
    logic [SLP_W-1:0] pump_cnt_r, pump_cnt_nxt;              // Pump wait timer
    logic             rst_prev_r, rst_prev_nxt;              // Previous reset input
    logic             clr_r, clr_nxt;                        // Fault clear pulse
    logic [CNT_W-1:0] dead_cyc_r, dead_cyc_nxt;              // Dead time in cycles
    logic             drive_en;                              // Gates permitted
    bgd_gate_t        gate_w [NPHASE];                       // Per phase gate pairs

    // Power sequencing next values
    always_comb
    begin
        pw_nxt       = pw_r;
        low_cnt_nxt  = low_cnt_r;
        pump_cnt_nxt = pump_cnt_r;
        rst_prev_nxt = sleep_reset_n_i;
        clr_nxt      = 1'b0;
        if (!sleep_reset_n_i)
        begin
            if (low_cnt_r < SLP_W'(RES_CYC))
                low_cnt_nxt = low_cnt_r + 1'b1;
            else
                pw_nxt = PW_SLEEP;
        end
        else
            low_cnt_nxt = '0;
        // Release after a pulse clears faults; sleep clears on entry too
        if (sleep_reset_n_i && !rst_prev_r)
        begin
            clr_nxt = 1'b1;
            if (pw_r == PW_SLEEP)
            begin
                pw_nxt       = PW_PUMP_WAIT;
                pump_cnt_nxt = '0;
            end
        end
        if (pw_nxt == PW_SLEEP)
            clr_nxt = 1'b1;
        if (pw_r == PW_PUMP_WAIT && sleep_reset_n_i)
        begin
            // Pump report ends the wait; counter only counts the time taken, saturating at PUMP_CYC
            if (pump_cnt_r < SLP_W'(PUMP_CYC))
                pump_cnt_nxt = pump_cnt_r + 1'b1;
            if (pump_valid_i)
                pw_nxt = PW_RUN;
        end
    end

    // Dead time from the shared setting, never below the least value
    always_comb
    begin
        if (dead_time_setting_i <= DT_MIN_SETTING)
            dead_cyc_nxt = CNT_W'(DT_MIN_CYC);
        else
            dead_cyc_nxt = CNT_W'((32'(dead_time_setting_i) * DT_STEP_NS) / CLK_PERIOD_NS);
    end

    // Register power state and dead time
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            pw_r       <= PW_PUMP_WAIT;
            low_cnt_r  <= '0;
            pump_cnt_r <= '0;
            rst_prev_r <= 1'b1;
            clr_r      <= 1'b0;
            dead_cyc_r <= CNT_W'(DT_MIN_CYC);
        end
        else
        begin
            pw_r       <= pw_nxt;
            low_cnt_r  <= low_cnt_nxt;
            pump_cnt_r <= pump_cnt_nxt;
            rst_prev_r <= rst_prev_nxt;
            clr_r      <= clr_nxt;
            dead_cyc_r <= dead_cyc_nxt;
        end
    end

    // Gates only in run state with reset input high
    assign drive_en      = (pw_r == PW_RUN) && sleep_reset_n_i;
    assign sleep_o       = (pw_r == PW_SLEEP);
    assign pump_enable_o = (pw_r != PW_SLEEP);
    assign fault_clear_o = clr_r;

    // One phase engine per bridge leg
    for (genvar p = 0; p < NPHASE; p++)
    begin : g_phase
        bgd_phase u_phase (
            .ref_clk_i     (ref_clk_i),
            .rst_n_i       (rst_n_i),
            .enable_i      (drive_en),
            .want_high_i   (phase_high_i[p] && pwm_i),
            .want_low_i    (phase_low_i[p] || (phase_high_i[p] && !pwm_i)),
            .boot_on_ok_i  (boot_on_ok_i[p]),
            .boot_off_ok_i (boot_off_ok_i[p]),
            .dead_cyc_i    (dead_cyc_r),
            .clear_fault_i (clr_r),
            .gate_o        (gate_w[p]),
            .boot_fault_o  (boot_fault_o[p])
        );
        assign high_gate_out_o[p] = gate_w[p].high;
        assign low_gate_out_o[p]  = gate_w[p].low;
    end
endmodule
`default_nettype wire

// File: testbench/bgd_checker.sv
// Assertion checker for the bridge gate drive control top
`timescale 1ns/1ps
`default_nettype none
module bgd_checker
    import bgd_pkg::*;
#(
    parameter int unsigned RES_CYC  = RES_PULSE_CYC, // Reset pulse time
    parameter int unsigned PUMP_CYC = PUMP_WAIT_CYC  // Pump settle limit
)
(
    input wire logic              ref_clk_i,
    input wire logic              rst_n_i,
    input wire logic              sleep_reset_n_i,
    input wire logic              pwm_i,
    input wire logic [NPHASE-1:0] phase_high_i,
    input wire logic [NPHASE-1:0] phase_low_i,
    input wire logic [NPHASE-1:0] boot_on_ok_i,
    input wire logic [NPHASE-1:0] boot_off_ok_i,
    input wire logic              pump_valid_i,
    input wire logic [DT_W-1:0]   dead_time_setting_i,
    input wire logic [NPHASE-1:0] high_gate_out_o,
    input wire logic [NPHASE-1:0] low_gate_out_o,
    input wire logic [NPHASE-1:0] boot_fault_o,
    input wire logic              fault_clear_o,
    input wire logic              sleep_o,
    input wire logic              pump_enable_o
);
    logic [7:0]  idle_r [NPHASE]; // Cycles with both gates of a phase off
    logic [15:0] low_r;           // Cycles the sleep input stayed low
    logic        pw_r;            // Still waiting for pump after sleep or reset
    logic [7:0]  dcyc;            // Dead cycles the setting asks for
    // Floor of 100 ns; odd settings lose one 50 ns step at this clock
    assign dcyc = (dead_time_setting_i <= 6'h02) ? 8'h01 : {3'h0, dead_time_setting_i[5:1]};
    // Helper counters; idle counts saturate so long idles never wrap
    always_ff @(posedge ref_clk_i)
    begin
        for (int i = 0; i < NPHASE; i++)
            idle_r[i] <= (!rst_n_i || high_gate_out_o[i] || low_gate_out_o[i]) ? 8'h00
                         : idle_r[i] + {7'h00, idle_r[i] != 8'hff};
        low_r <= (!rst_n_i || sleep_reset_n_i) ? 16'h0000 : low_r + 16'h0001;
        pw_r  <= (!rst_n_i || sleep_o) ? 1'b1 : pw_r && !pump_valid_i;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // PWM falls and stays low
    sequence chop_s;
        $fell(pwm_i) ##1 !pwm_i;
    endsequence
    // Per phase gate relations
    for (genvar g = 0; g < NPHASE; g++)
    begin : g_ph
        no_shoot_a: assert property (!(high_gate_out_o[g] && low_gate_out_o[g]))
            else $error("both gates of one phase on");
        boot_first_a: assert property ($rose(high_gate_out_o[g]) |-> $past(boot_on_ok_i[g]))
            else $error("high side on with weak bootstrap");
        dead_gap_a: assert property (($rose(high_gate_out_o[g]) || $rose(low_gate_out_o[g])) |-> idle_r[g] >= dcyc)
            else $error("dead time too short");
        fault_off_a: assert property (boot_fault_o[g] |-> !high_gate_out_o[g])
            else $error("faulted phase drives high side");
    end
    pwm_chop_a: assert property (chop_s |-> ##1 (high_gate_out_o == '0))
        else $error("pwm low kept a high side on");
    sleep_off_a: assert property (sleep_o |-> !pump_enable_o && high_gate_out_o == '0 && low_gate_out_o == '0)
        else $error("sleep with pump or gates on");
    sleep_entry_a: assert property (low_r >= RES_CYC + 3 |-> sleep_o)
        else $error("long reset low without sleep");
    sleep_clear_a: assert property (sleep_o |=> boot_fault_o == '0)
        else $error("fault kept in sleep");
    pump_hold_a: assert property (pw_r |-> high_gate_out_o == '0 && low_gate_out_o == '0)
        else $error("gate on before pump valid");
    clear_pulse_a: assert property ($rose(sleep_reset_n_i) |-> ##[0:2] fault_clear_o)
        else $error("no fault clear after reset pulse");
    clear_empty_a: assert property (fault_clear_o |=> boot_fault_o == '0)
        else $error("fault survived clear");
endmodule
bind bgd_top bgd_checker #(.RES_CYC(RES_CYC), .PUMP_CYC(PUMP_CYC)) u_chk (.*);
`default_nettype wire

// File: testbench/bgd_bridge_model.sv
// Behavioural power bridge with bootstrap capacitors for the gate drive bench
`timescale 1ns/1ps
`default_nettype none
module bgd_bridge_model
    import bgd_pkg::*;
(
    input  wire logic              ref_clk_i,     // System clock
    input  wire logic [NPHASE-1:0] high_gate_i,   // High-side gate drives
    input  wire logic [NPHASE-1:0] low_gate_i,    // Low-side gate drives
    input  wire logic [NPHASE-1:0] stuck_i,       // Capacitor that never charges
    output logic      [NPHASE-1:0] boot_on_ok_o,  // Above turn-on level
    output logic      [NPHASE-1:0] boot_off_ok_o  // Above turn-off level
);
    logic [4:0] lvl [NPHASE] = '{default: 5'h00}; // Charge level, starts empty
    logic [3:0] tick = 4'h0;                      // Leak prescaler
    // Slow leak while high forces periodic recharge at full duty
    always @(posedge ref_clk_i)
    begin
        tick <= tick + 4'h1;
        for (int i = 0; i < NPHASE; i++)
            if (stuck_i[i])
                lvl[i] <= 5'h00;
            else if (low_gate_i[i] && lvl[i] != 5'h1f)
                lvl[i] <= lvl[i] + 5'h01;
            else if (high_gate_i[i] && tick == 4'h0 && lvl[i] != 5'h00)
                lvl[i] <= lvl[i] - 5'h01;
    end
    // Two thresholds with a hysteresis gap
    always_comb
        for (int i = 0; i < NPHASE; i++)
        begin
            boot_on_ok_o[i]  = lvl[i] >= 5'h14;
            boot_off_ok_o[i] = lvl[i] >= 5'h08;
        end
endmodule
`default_nettype wire

// File: testbench/bgd_top_tb.sv
// Self-checking testbench for the bridge gate drive control top
`timescale 1ns/1ps
`default_nettype none
module bgd_top_tb
    import bgd_pkg::*;
;
    localparam int RES_T = 8; // Shortened reset pulse time
    logic ref_clk_i = 1'b0;
    logic rst_n_i, sleep_reset_n_i, pwm_i, pump_valid_i, fault_clear_o, sleep_o, pump_enable_o;
    logic [NPHASE-1:0] phase_high_i, phase_low_i, boot_on_ok_i, boot_off_ok_i, stuck;
    logic [NPHASE-1:0] high_gate_out_o, low_gate_out_o, boot_fault_o;
    logic [DT_W-1:0] dead_time_setting_i;
    int fail_count = 0;
    int check_count = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    bgd_top #(.RES_CYC(RES_T), .PUMP_CYC(50)) dut (.*);
    bgd_bridge_model u_bridge (.ref_clk_i(ref_clk_i), .high_gate_i(high_gate_out_o), .low_gate_i(low_gate_out_o),
        .stuck_i(stuck), .boot_on_ok_o(boot_on_ok_i), .boot_off_ok_o(boot_off_ok_i));
    // Inputs move 1 ns after the edge, clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Cycles from low-side request on all phases to all gates on
    task automatic measure(input logic [5:0] s, output int c);
        dead_time_setting_i = s;
        step(40);
        phase_low_i = 3'b111;
        for (c = 0; c < 100 && low_gate_out_o === 3'b000; c++)
            step(1);
        check(low_gate_out_o === 3'b111, "phases differ in dead time");
        phase_low_i = 3'b000;
    endtask
    // Relative to setting 0, so pipeline latency cancels out
    task automatic t_dead();
        int base, c;
        logic [5:0] tab [6] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h18, 6'h3f};
        measure(6'h00, base);
        foreach (tab[k])
        begin
            measure(tab[k], c);
            check(c - base == ((tab[k] <= 6'h02) ? 0 : tab[k] / 2 - 1), "dead time length");
        end
        $display("dead time test done");
    endtask
    // Empty capacitor, then sag under full duty, then chop
    task automatic t_charge();
        int n;
        logic seen;
        seen = 1'b0;
        phase_high_i = 3'b001;
        for (n = 0; n < 400 && high_gate_out_o[0] !== 1'b1; n++)
        begin
            seen |= low_gate_out_o[0] === 1'b1;
            step(1);
        end
        check(seen && high_gate_out_o[0] === 1'b1, "no recharge before high side");
        seen = 1'b0;
        for (n = 0; n < 600 && !seen; n++)
        begin
            seen = low_gate_out_o[0] === 1'b1;
            step(1);
        end
        check(seen, "no recharge on sag");
        for (n = 0; n < 400 && high_gate_out_o[0] !== 1'b1; n++)
            step(1);
        check(high_gate_out_o[0] === 1'b1 && boot_fault_o === 3'b000, "high side not restored");
        pwm_i = 1'b0;
        step(3);
        check(high_gate_out_o[0] === 1'b0, "pwm low left high side on");
        step(40);
        check(low_gate_out_o[0] === 1'b1, "pwm low gave no low side");
        pwm_i = 1'b1;
        phase_high_i = 3'b000;
        step(60);
        $display("charge test done");
    endtask
    // Dead capacitor faults; reset low for low_n cycles clears it
    task automatic t_fault(input int low_n);
        stuck = 3'b010;
        phase_high_i = 3'b010;
        step(300);
        check(boot_fault_o === 3'b010 && high_gate_out_o === 3'b000, "no bootstrap fault");
        phase_high_i = 3'b000;
        stuck = 3'b000;
        sleep_reset_n_i = 1'b0;
        step(low_n);
        check(sleep_o === (low_n > RES_T) && pump_enable_o === (low_n <= RES_T), "wrong sleep state");
        sleep_reset_n_i = 1'b1;
        step(3);
        check(boot_fault_o === 3'b000, "fault not cleared");
        $display("fault test done, low %0d", low_n);
    endtask
    // Gates held off after sleep until the pump reports valid
    task automatic t_pump();
        int n;
        sleep_reset_n_i = 1'b0;
        step(RES_T + 12);
        pump_valid_i = 1'b0;
        phase_low_i = 3'b100;
        sleep_reset_n_i = 1'b1;
        step(30);
        check(low_gate_out_o === 3'b000 && sleep_o === 1'b0, "gate before pump valid");
        pump_valid_i = 1'b1;
        for (n = 0; n < 100 && low_gate_out_o[2] !== 1'b1; n++)
            step(1);
        check(low_gate_out_o[2] === 1'b1, "no drive after pump valid");
        phase_low_i = 3'b000;
        $display("pump test done");
    endtask
    initial
    begin
        rst_n_i = 1'b0;
        sleep_reset_n_i = 1'b1;
        pwm_i = 1'b1;
        pump_valid_i = 1'b1;
        phase_high_i = 3'b000;
        phase_low_i = 3'b000;
        stuck = 3'b000;
        dead_time_setting_i = 6'h04;
        step(20);
        rst_n_i = 1'b1;
        step(2);
        t_dead();
        t_charge();
        t_fault(RES_T - 3);
        t_fault(RES_T + 12);
        t_pump();
        give_verdict();
    end
    // Watchdog, about five times the expected run
    initial
    begin
        #(8000 * 100);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
`default_nettype wire
